// File: logic/lfe_top.sv
// lane flag register, expander mask and post-rotation control behind an ahb-lite slave
//
// Chosen here: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`include "lfe_regs.svh"

module lfe_top (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // operation from the split alu
    input wire lfe_pkg::lfe_op_s op,
    // results toward the alu
    output logic [31:0] exp_mask,
    output logic [31:0] lane_flag_reg
);
    import lfe_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // lanes or bits for a size code, zero for reserved codes
    function automatic logic [2:0] size_count(input logic [2:0] code);
        logic [2:0] n;
        n = 3'd0;
        if (code == `LFE_SIZE_8) begin
            n = 3'd4;
        end else if (code == `LFE_SIZE_16) begin
            n = 3'd2;
        end else if (code == `LFE_SIZE_32) begin
            n = 3'd1;
        end
        return n;
    endfunction

    // rotate a 32-bit word left by up to four
    function automatic logic [31:0] rotl(input logic [31:0] v, input logic [2:0] amt);
        logic [63:0] d;
        d = {v, v} << amt;
        return d[63:32];
    endfunction

    // mask of the low n lane bits
    function automatic logic [31:0] low_bits(input logic [2:0] n);
        logic [4:0] m;
        m = (5'd1 << n) - 5'd1;
        return {28'h0, m[3:0]};
    endfunction

    // expander: pick n flag bits from top or bottom and widen each to its lane
    function automatic logic [31:0] expand_mask(input logic [31:0] lf, input logic r, input logic [2:0] code);
        logic [2:0] n;
        logic [3:0] sel;
        logic [31:0] m;
        logic [4:0] b5;
        logic [1:0] idx;
        n = size_count(code);
        sel = r ? (lf[31:28] >> (3'd4 - n)) : lf[3:0];
        m = 32'h0;
        for (int b = 0; b < 32; b++) begin
            b5 = 5'(b);
            idx = (n == 3'd4) ? b5[4:3] : ((n == 3'd2) ? {1'b0, b5[4]} : 2'd0);
            m[b] = (n != 3'd0) && sel[idx];
        end
        return m;
    endfunction

    // per-lane flag bits, packed into the low bits
    function automatic logic [3:0] lane_flags(input lfe_op_s o, input logic [2:0] n, input logic [1:0] src,
                                              input logic carry_mode);
        logic [3:0] f;
        logic [1:0] seg;
        logic [31:0] lmask;
        f = 4'h0;
        for (int i = 0; i < 4; i++) begin
            seg = (n == 3'd4) ? 2'(i) : ((n == 3'd2) ? 2'(2 * i + 1) : 2'd3);
            lmask = (n == 3'd4) ? (32'h0000_00ff << (8 * i)) :
                    ((n == 3'd2) ? (32'h0000_ffff << (16 * i)) : 32'hffff_ffff);
            if (3'(i) < n) begin
                if (carry_mode) begin
                    f[i] = o.lane_carry[seg];
                end else if (src == `LFE_SRC_ZERO) begin
                    f[i] = ~|(o.result & lmask);
                end else if (src == `LFE_SRC_SIGN) begin
                    f[i] = o.result[{seg, 3'd7}];
                end else begin
                    f[i] = o.msb_prop[seg] ^ o.lane_carry[seg];
                end
            end
        end
        return f;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // status word fields

    logic [`LFE_SW_WIDTH-1:0] status_word;
    wire [2:0] asize = status_word[`LFE_SW_ASIZE_LSB +: 3];
    wire [2:0] msize = status_word[`LFE_SW_MSIZE_LSB +: 3];
    wire rot_sel = status_word[`LFE_SW_ROT_BIT];
    wire [1:0] flag_source_select = status_word[`LFE_SW_SRC_LSB +: 2];

    wire [2:0] exp_bits = size_count(msize);
    wire [2:0] split_lanes = size_count(asize);

    ////////////////////////////////////////////////////////////////////////////
    // operation decode

    wire is_save = (op.fmod == LFE_FM_SAVE) || (op.fmod == LFE_FM_SAVE_ROT) || (op.fmod == LFE_FM_SAVE_ZERO);
    wire is_carry = (op.fmod == LFE_FM_CARRY) || (op.fmod == LFE_FM_CARRY_ROT) || (op.fmod == LFE_FM_CARRY_ZERO);
    wire is_zero = (op.fmod == LFE_FM_SAVE_ZERO) || (op.fmod == LFE_FM_CARRY_ZERO);
    wire is_split_rot = (op.fmod == LFE_FM_SAVE_ROT) || (op.fmod == LFE_FM_CARRY_ROT);
    // reserved flag source stops the save modifiers from saving flags; LFE_FM_SAVE_ROT still rotates the register
    wire save_en = op.valid && (split_lanes != 3'd0) &&
                   (is_carry || (is_save && flag_source_select != `LFE_SRC_RSVD));
    wire [3:0] flags = lane_flags(op, split_lanes, flag_source_select, is_carry);

    wire [31:0] save_mask = low_bits(split_lanes);
    wire [31:0] save_base = is_zero ? 32'h0 : lane_flag_reg;
    wire [31:0] saved = save_en ? ((save_base & ~save_mask) | ({28'h0, flags} & save_mask)) : lane_flag_reg;

    // split rotation wins over expander rotation
    // expander rotation skipped when split rotation asked
    wire do_split_rot = op.valid && is_split_rot;
    // rotate bit clear means no width rotation
    wire do_exp_rot = op.valid && op.uses_exp && rot_sel && !is_split_rot;
    wire [31:0] op_lane_flag = do_split_rot ? rotl(saved, split_lanes) :
                               (do_exp_rot ? rotl(saved, exp_bits) : saved);

    wire [31:0] next_exp_mask = (op.valid && op.uses_exp) ? expand_mask(lane_flag_reg, rot_sel, msize) : exp_mask;

    ////////////////////////////////////////////////////////////////////////////
    // ahb-lite slave: zero wait states, writes land at the end of the data phase

    logic wr_pend;
    logic [11:0] wr_addr;
    wire addr_phase = hsel && htrans[1] && hready;
    wire wr_sw = wr_pend && (wr_addr == `LFE_OFF_STATUS_WORD);
    wire wr_lf = wr_pend && (wr_addr == `LFE_OFF_LANE_FLAG);

    // fields change only on a software write
    wire [`LFE_SW_WIDTH-1:0] next_status_word = wr_sw ? hwdata[`LFE_SW_WIDTH-1:0] : status_word;
    // hardware update beats a software write in the same cycle
    wire [31:0] next_lane_flag = op.valid ? op_lane_flag : (wr_lf ? hwdata : lane_flag_reg);

    // read mux sees post-edge values so a write followed by a read returns new data
    wire [31:0] rd_value = (haddr == `LFE_OFF_STATUS_WORD) ? {23'h0, next_status_word} :
                           (haddr == `LFE_OFF_LANE_FLAG) ? next_lane_flag :
                           (haddr == `LFE_OFF_EXP_MASK) ? next_exp_mask : 32'h0;

    // bus handshake registers
    always_ff @(posedge clock) begin
        if (srst) begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h0;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend <= addr_phase && hwrite;
            wr_addr <= haddr;
            hrdata <= (addr_phase && !hwrite) ? rd_value : 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // block state
    always_ff @(posedge clock) begin
        if (srst) begin
            status_word <= `LFE_RST_STATUS_WORD;
            lane_flag_reg <= `LFE_RST_LANE_FLAG;
            exp_mask <= `LFE_RST_EXP_MASK;
        end else begin
            status_word <= next_status_word;
            lane_flag_reg <= next_lane_flag;
            exp_mask <= next_exp_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    wire exp_op = op.valid && op.uses_exp;

    a_mask_from_top: assert property (
        exp_op && rot_sel && msize == `LFE_SIZE_8 && op.fmod == LFE_FM_SAVE_ROT
        |=> exp_mask[31:24] == {8{$past(lane_flag_reg[31])}} && exp_mask[7:0] == {8{$past(lane_flag_reg[28])}})
        else $error("mask not taken from top of lane flags");

    a_exp_width_rot: assert property (
        exp_op && rot_sel && msize == `LFE_SIZE_16 && op.fmod == LFE_FM_MULTI
        |=> lane_flag_reg == rotl($past(lane_flag_reg), 3'd2))
        else $error("expander width rotation wrong");

    a_split_rot_wins: assert property (
        exp_op && rot_sel && msize == `LFE_SIZE_8 && asize == `LFE_SIZE_32 && op.fmod == LFE_FM_CARRY_ROT
        |=> lane_flag_reg[1] == $past(op.lane_carry[3]) && lane_flag_reg[0] == $past(lane_flag_reg[31]))
        else $error("split rotation did not replace width rotation");

    a_low_no_rot: assert property (
        exp_op && !rot_sel && msize == `LFE_SIZE_8 && op.fmod == LFE_FM_NONE
        |=> $stable(lane_flag_reg) && exp_mask[7:0] == {8{$past(lane_flag_reg[0])}})
        else $error("low bits or rotation wrong with rotate bit clear");

    a_ext_sign_bit: assert property (
        op.valid && op.fmod == LFE_FM_SAVE && flag_source_select == `LFE_SRC_EXT && asize == `LFE_SIZE_32
        && !(op.uses_exp && rot_sel)
        |=> lane_flag_reg[0] == ($past(op.msb_prop[3]) ^ $past(op.lane_carry[3])))
        else $error("extended sign flag wrong");

    a_carry_ignores_src: assert property (
        op.valid && op.fmod == LFE_FM_CARRY && flag_source_select == `LFE_SRC_RSVD && asize == `LFE_SIZE_16
        && !(op.uses_exp && rot_sel)
        |=> lane_flag_reg[1:0] == {$past(op.lane_carry[3]), $past(op.lane_carry[1])})
        else $error("carry save depends on flag source");

    a_zero_save_count: assert property (
        op.valid && op.fmod == LFE_FM_SAVE_ZERO && asize == `LFE_SIZE_8 && flag_source_select == `LFE_SRC_ZERO
        && !(op.uses_exp && rot_sel)
        |=> lane_flag_reg[31:4] == 28'h0 && lane_flag_reg[0] == ($past(op.result[7:0]) == 8'h00))
        else $error("flag save set wrong number of bits");

    a_save_rot_amount: assert property (
        op.valid && op.fmod == LFE_FM_SAVE_ROT && asize == `LFE_SIZE_8
        |=> lane_flag_reg[3:0] == $past(lane_flag_reg[31:28]))
        else $error("rotating save did not rotate by four");

    a_fields_hold: assert property (
        !wr_sw ##1 !wr_sw |-> $stable(status_word) && $stable(rot_sel))
        else $error("status fields changed without a write");

    // flag sources, rotations and reserved codes, one property per corner
    // guards on uses_exp and the rotate bit keep the expander post-rotation
    // from moving saved bits away from where a property looks for them
    a_zero_flag_src: assert property (
        op.valid && op.fmod == LFE_FM_SAVE && flag_source_select == `LFE_SRC_ZERO && asize == `LFE_SIZE_8
        && !(op.uses_exp && rot_sel)
        |=> lane_flag_reg[0] == ($past(op.result[7:0]) == 8'h00)
        && lane_flag_reg[3] == ($past(op.result[31:24]) == 8'h00)
        && lane_flag_reg[31:4] == $past(lane_flag_reg[31:4]))
        else $error("zero flag source wrong");

    a_sign_flag_src: assert property (
        op.valid && op.fmod == LFE_FM_SAVE_ROT && flag_source_select == `LFE_SRC_SIGN && asize == `LFE_SIZE_8
        |=> lane_flag_reg[7:4] == {$past(op.result[31]), $past(op.result[23]), $past(op.result[15]),
        $past(op.result[7])})
        else $error("sign flag source wrong");

    a_rsvd_src_hold: assert property (
        op.valid && op.fmod == LFE_FM_SAVE && flag_source_select == `LFE_SRC_RSVD && !(op.uses_exp && rot_sel)
        |=> $stable(lane_flag_reg))
        else $error("reserved flag source changed the lane flags");

    a_exp_rot_byte: assert property (
        exp_op && rot_sel && msize == `LFE_SIZE_8 && op.fmod == LFE_FM_MULTI
        |=> lane_flag_reg == rotl($past(lane_flag_reg), 3'd4))
        else $error("byte expander rotation wrong");

    a_exp_rot_word: assert property (
        exp_op && rot_sel && msize == `LFE_SIZE_32 && op.fmod == LFE_FM_MULTI
        |=> lane_flag_reg == rotl($past(lane_flag_reg), 3'd1))
        else $error("word expander rotation wrong");

    a_mask_word_top: assert property (
        exp_op && rot_sel && msize == `LFE_SIZE_32
        |=> exp_mask == {32{$past(lane_flag_reg[31])}})
        else $error("word mask not taken from the top bit");

    a_mask_halfword: assert property (
        exp_op && rot_sel && msize == `LFE_SIZE_16
        |=> exp_mask == {{16{$past(lane_flag_reg[31])}}, {16{$past(lane_flag_reg[30])}}})
        else $error("halfword mask expansion wrong");

    a_mask_low_byte: assert property (
        exp_op && !rot_sel && msize == `LFE_SIZE_8
        |=> exp_mask == {{8{$past(lane_flag_reg[3])}}, {8{$past(lane_flag_reg[2])}},
        {8{$past(lane_flag_reg[1])}}, {8{$past(lane_flag_reg[0])}}})
        else $error("byte mask not taken from the low bits");

    a_mask_rsvd_zero: assert property (
        exp_op && op.fmod == LFE_FM_MULTI && (!msize[2] || &msize)
        |=> exp_mask == 32'h0 && $stable(lane_flag_reg))
        else $error("reserved expander width not inert");

    a_carry_word_lane: assert property (
        op.valid && op.fmod == LFE_FM_CARRY && asize == `LFE_SIZE_32 && !(op.uses_exp && rot_sel)
        |=> lane_flag_reg[0] == $past(op.lane_carry[3]) && lane_flag_reg[31:1] == $past(lane_flag_reg[31:1]))
        else $error("word lane carry save wrong");

    a_split_rot_half: assert property (
        op.valid && (op.fmod == LFE_FM_SAVE_ROT || op.fmod == LFE_FM_CARRY_ROT) && asize == `LFE_SIZE_16
        |=> lane_flag_reg[1:0] == $past(lane_flag_reg[31:30]))
        else $error("halfword split rotation wrong");

    a_rsvd_split_hold: assert property (
        op.valid && op.fmod == LFE_FM_SAVE_ROT && (!asize[2] || &asize)
        |=> $stable(lane_flag_reg))
        else $error("reserved split width changed the lane flags");

    a_mask_held: assert property (
        !exp_op |=> $stable(exp_mask))
        else $error("mask changed without an expander operation");

    c_exp_rotate: cover property (exp_op && rot_sel && op.fmod == LFE_FM_NONE && msize == `LFE_SIZE_8);
    c_save_rot: cover property (op.valid && op.fmod == LFE_FM_SAVE_ROT && asize == `LFE_SIZE_16);
    c_carry_zero: cover property (op.valid && op.fmod == LFE_FM_CARRY_ZERO && asize == `LFE_SIZE_8);
    c_write_read: cover property (wr_sw ##1 addr_phase && !hwrite);
    c_carry_word_rot: cover property (op.valid && op.fmod == LFE_FM_CARRY_ROT && asize == `LFE_SIZE_32);

endmodule

// File: logic/lfe_regs.svh
// register offsets, field positions, reset values for the lane flag expander control
`ifndef LFE_REGS_SVH
`define LFE_REGS_SVH

// byte offsets on the register bus
`define LFE_OFF_STATUS_WORD 12'h000
`define LFE_OFF_LANE_FLAG 12'h004
`define LFE_OFF_EXP_MASK 12'h008

// status_word field positions
`define LFE_SW_ASIZE_LSB 0
`define LFE_SW_MSIZE_LSB 3
`define LFE_SW_ROT_BIT 6
`define LFE_SW_SRC_LSB 7
`define LFE_SW_WIDTH 9

// size codes shared by expander width and split width
`define LFE_SIZE_8 3'h4
`define LFE_SIZE_16 3'h5
`define LFE_SIZE_32 3'h6

// flag source encodings
`define LFE_SRC_ZERO 2'h0
`define LFE_SRC_SIGN 2'h1
`define LFE_SRC_EXT 2'h2
`define LFE_SRC_RSVD 2'h3

// reset values
`define LFE_RST_STATUS_WORD 9'h000
`define LFE_RST_LANE_FLAG 32'h0000_0000
`define LFE_RST_EXP_MASK 32'h0000_0000

`endif

// File: logic/lfe_pkg.sv
// types shared by the lane flag expander control
package lfe_pkg;

    // alu function modifier as seen by this block
    typedef enum logic [2:0] {
        LFE_FM_NONE = 3'b000,
        LFE_FM_MULTI = 3'b001,
        LFE_FM_SAVE = 3'b010,
        LFE_FM_SAVE_ROT = 3'b011,
        LFE_FM_SAVE_ZERO = 3'b100,
        LFE_FM_CARRY = 3'b101,
        LFE_FM_CARRY_ROT = 3'b110,
        LFE_FM_CARRY_ZERO = 3'b111
    } lfe_fmod_e;

    // one alu operation reported by the split alu
    typedef struct packed {
        logic valid;
        logic uses_exp;
        lfe_fmod_e fmod;
        logic [31:0] result;
        logic [3:0] lane_carry;
        logic [3:0] msb_prop;
    } lfe_op_s;

endpackage

// File: verif/lfe_alu_model.sv
// behavioural split alu feeding operations into the flag control
`timescale 1ns/1ps
module lfe_alu_model (
    // commanded operation
    input wire logic go,
    input wire logic ue,
    input wire lfe_pkg::lfe_fmod_e fm,
    input wire logic [2:0] asz,
    input wire logic [31:0] a,
    input wire logic [31:0] b,
    // toward the block
    output lfe_pkg::lfe_op_s op
);
    import lfe_pkg::*;
    logic [31:0] s;
    logic [3:0] cy;
    logic [3:0] pr;
    logic c;
    // carry chain cut at each lane edge, so carries and propagates stay per lane
    always_comb begin
        c = 1'b0;
        for (int k = 0; k < 4; k++) begin
            if (k == 0 || asz == 3'h4 || (asz == 3'h5 && k == 2)) begin
                c = 1'b0;
            end
            {c, s[8*k +: 8]} = {1'b0, a[8*k +: 8]} + {1'b0, b[8*k +: 8]} + {8'h00, c};
            cy[k] = c;
            pr[k] = a[8*k+7] ^ b[8*k+7];
        end
    end
    assign op = '{valid: go, uses_exp: ue, fmod: fm, result: s, lane_carry: cy, msb_prop: pr};
endmodule

// File: verif/tb_lane_flag_expander_control.sv
// self-checking bench for the lane flag expander control
`timescale 1ns/1ps
`include "lfe_regs.svh"
module tb_lane_flag_expander_control;
    import lfe_pkg::*;
    typedef struct packed {lfe_fmod_e fm; logic ue; logic [8:0] sw; logic [31:0] lf; logic [31:0] a;} lfe_row_s;
    logic clock, srst, hsel, hwrite, hready, hreadyout, hresp, go, ue;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize, asz;
    logic [31:0] hwdata, hrdata, exp_mask, lane_flag_reg, a, b, q, ef, em;
    lfe_fmod_e fm;
    lfe_op_s op;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    // rows: modifier, expander use, status word, starting flags, operand a (b is fixed)
    lfe_row_s rows [20] = '{
        '{LFE_FM_SAVE, 1'b0, 9'h024, 32'hffff_fff0, 32'h0100_ff00},
        '{LFE_FM_SAVE_ROT, 1'b1, 9'h0e4, 32'ha000_0005, 32'h80ff_7f01},
        '{LFE_FM_SAVE_ZERO, 1'b0, 9'h12d, 32'h0f0f_0f0f, 32'h7fff_8000},
        '{LFE_FM_CARRY, 1'b0, 9'h1a6, 32'h0000_00f0, 32'hffff_ffff},
        '{LFE_FM_CARRY_ROT, 1'b1, 9'h025, 32'h8000_000a, 32'hffff_0000},
        '{LFE_FM_CARRY_ZERO, 1'b1, 9'h0f4, 32'hc000_0000, 32'hff00_ff00},
        '{LFE_FM_MULTI, 1'b1, 9'h064, 32'h9000_0001, 32'h0000_0000},
        '{LFE_FM_NONE, 1'b1, 9'h06c, 32'h4000_0003, 32'h0000_0000},
        '{LFE_FM_MULTI, 1'b1, 9'h074, 32'h8000_0002, 32'h0000_0000},
        '{LFE_FM_MULTI, 1'b1, 9'h024, 32'hf000_0005, 32'h0000_0000},
        '{LFE_FM_MULTI, 1'b1, 9'h07c, 32'hf000_000f, 32'h0000_0000},
        '{LFE_FM_SAVE, 1'b0, 9'h1a4, 32'h0000_00a0, 32'h0000_0000},
        '{LFE_FM_SAVE_ROT, 1'b0, 9'h0a3, 32'h1234_5678, 32'h8080_8080},
        '{LFE_FM_SAVE, 1'b1, 9'h16e, 32'h4000_0000, 32'h7fff_ffff},
        '{LFE_FM_MULTI, 1'b1, 9'h054, 32'hf000_000f, 32'h0000_0000},
        '{LFE_FM_NONE, 1'b1, 9'h024, 32'h0000_0005, 32'h0000_0000},
        '{LFE_FM_SAVE_ZERO, 1'b0, 9'h004, 32'hffff_ffff, 32'h00ff_00ff},
        '{LFE_FM_CARRY, 1'b0, 9'h185, 32'h0000_0000, 32'hffff_ffff},
        '{LFE_FM_CARRY_ROT, 1'b1, 9'h066, 32'h8000_000a, 32'hffff_ffff},
        '{LFE_FM_SAVE, 1'b0, 9'h106, 32'h0000_0001, 32'h7fff_ffff}};
    assign hready = hreadyout;
    lfe_top dut_u (.clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .op(op), .exp_mask(exp_mask), .lane_flag_reg(lane_flag_reg));
    lfe_alu_model alu_u (.go(go), .ue(ue), .fm(fm), .asz(asz), .a(a), .b(b), .op(op));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic int nl(input logic [2:0] c);
        return (c == `LFE_SIZE_8) ? 4 : (c == `LFE_SIZE_16) ? 2 : (c == `LFE_SIZE_32) ? 1 : 0;
    endfunction
    function automatic logic [31:0] rotl(input logic [31:0] x, input int n);
        return (n == 0) ? x : (x << n) | (x >> (32 - n));
    endfunction
    // expected flags and mask after one operation
    task automatic model(input logic [8:0] sw, input lfe_op_s o);
        int na, nm, w, i;
        logic [3:0] fl;
        logic [31:0] nf;
        logic cm, sm;
        na = nl(sw[2:0]);
        nm = nl(sw[5:3]);
        cm = o.fmod inside {LFE_FM_CARRY, LFE_FM_CARRY_ROT, LFE_FM_CARRY_ZERO};
        sm = o.fmod inside {LFE_FM_SAVE, LFE_FM_SAVE_ROT, LFE_FM_SAVE_ZERO} && sw[8:7] != `LFE_SRC_RSVD;
        fl = 4'h0;
        nf = ef;
        for (int k = 0; k < na; k++) begin
            w = 32 / na;
            i = (k + 1) * w / 8 - 1;
            if (cm) fl[k] = o.lane_carry[i];
            else if (sw[8:7] == `LFE_SRC_ZERO) fl[k] = ((64'(o.result) >> (k * w)) & ((64'h1 << w) - 1)) == 0;
            else if (sw[8:7] == `LFE_SRC_SIGN) fl[k] = o.result[(k + 1) * w - 1];
            else fl[k] = o.msb_prop[i] ^ o.lane_carry[i];
        end
        if ((cm || sm) && na > 0) begin
            if (o.fmod inside {LFE_FM_SAVE_ZERO, LFE_FM_CARRY_ZERO}) nf = 32'h0;
            nf = (nf & ~((32'h1 << na) - 32'h1)) | 32'(fl);
        end
        // mask from top or bottom bits
        if (o.uses_exp) begin
            for (int j = 0; j < 32; j++) em[j] = (nm == 0) ? 1'b0 : ef[(sw[6] ? 32 - nm : 0) + j / (32 / nm)];
        end
        if (o.fmod inside {LFE_FM_SAVE_ROT, LFE_FM_CARRY_ROT}) nf = rotl(nf, na);
        else if (o.uses_exp && sw[6]) nf = rotl(nf, nm);
        ef = nf;
    endtask
    // one ahb-lite single transfer; waits on hready at both phases
    task automatic bus(input logic w, input logic [11:0] ad, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= ad;
        hwrite <= w;
        do @(posedge clock); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // n operations on consecutive cycles, results checked while they stand
    task automatic run_op(input logic [8:0] sw, input lfe_fmod_e f, input logic e, input logic [31:0] x, input int n);
        fm <= f;
        ue <= e;
        a <= x;
        b <= 32'h0000_0001;
        asz <= sw[2:0];
        go <= 1'b1;
        repeat (n) begin
            @(posedge clock);
            model(sw, op);
        end
        go <= 1'b0;
        @(posedge clock);
        check("flags", lane_flag_reg, ef);
        check("mask", exp_mask, em);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // hang guard; whole run needs well under this
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            stop_test();
        end
    end
    initial begin
        {srst, hsel, htrans, haddr, hwrite, hwdata, go, ue, a, b, asz} = '0;
        srst = 1'b1;
        hsize = 3'h2;
        fm = LFE_FM_NONE;
        ef = 32'h0;
        em = 32'h0;
        repeat (10) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        check("reset flags", lane_flag_reg, 32'h0);
        check("reset mask", exp_mask, 32'h0);
        check("resp", 32'(hresp), 32'h0);
        foreach (rows[i]) begin
            bus(1'b1, `LFE_OFF_LANE_FLAG, rows[i].lf);
            bus(1'b1, `LFE_OFF_STATUS_WORD, 32'(rows[i].sw));
            ef = rows[i].lf;
            run_op(rows[i].sw, rows[i].fm, rows[i].ue, rows[i].a, 1);
            bus(1'b0, `LFE_OFF_STATUS_WORD, 32'h0);
            check("status", q, 32'(rows[i].sw));
            bus(1'b0, `LFE_OFF_LANE_FLAG, 32'h0);
            check("flag read", q, ef);
        end
        // back-to-back expander ops under one status word
        bus(1'b1, `LFE_OFF_STATUS_WORD, 32'h0000_0064);
        bus(1'b1, `LFE_OFF_LANE_FLAG, 32'h1234_5678);
        ef = 32'h1234_5678;
        run_op(9'h064, LFE_FM_MULTI, 1'b1, 32'h0, 2);
        // read-only mask, unused status bits, unmapped place
        bus(1'b1, `LFE_OFF_EXP_MASK, 32'hdead_0000);
        bus(1'b0, `LFE_OFF_EXP_MASK, 32'h0);
        check("mask read", q, em);
        bus(1'b1, `LFE_OFF_STATUS_WORD, 32'hffff_ffff);
        bus(1'b0, `LFE_OFF_STATUS_WORD, 32'h0);
        check("status bits", q, 32'h0000_01ff);
        bus(1'b0, 12'h00c, 32'h0);
        check("unmapped", q, 32'h0);
        // second reset in mid-run
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        check("rerst flags", lane_flag_reg, 32'h0);
        check("rerst mask", exp_mask, 32'h0);
        bus(1'b0, `LFE_OFF_STATUS_WORD, 32'h0);
        check("rerst status", q, 32'h0);
        stop_test();
    end
endmodule
